// >>> pkg/pin_mux_pkg.sv
// constants, types and the per-group decode shared by the data pin function multiplexer
package pin_mux_pkg;

  // pin mode codes held in the system control register
  localparam logic [2:0] MODE_ALL_EXT = 3'h0;   // every pin is external data
  localparam logic [2:0] MODE_HI_FLAG = 3'h1;   // upper half flag/pwm lanes on the wide variant, all external data on the narrow one
  localparam logic [2:0] MODE_MID_FLAG = 3'h2;  // pins 15-8 become flags
  localparam logic [2:0] MODE_ALL_FLAG = 3'h3;  // all lower pins become flags
  localparam logic [2:0] MODE_ACQ_EXT = 3'h4;   // acquisition port plus external data
  localparam logic [2:0] MODE_ACQ_FLAG = 3'h5;  // acquisition port plus flags
  localparam logic [2:0] MODE_RESERVED = 3'h6;  // must not be selected
  localparam logic [2:0] MODE_ALL_HIZ = 3'h7;   // every pin three-stated

  // register bus layout
  localparam int ADDR_W = 8;                                // byte address width
  localparam logic [ADDR_W-1:0] OFS_SYS_CTRL = 8'h00;       // system_control_register
  localparam logic [ADDR_W-1:0] OFS_GROUP_SEL = 8'h04;      // flag or pwm per four-lane group
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;         // mode readback and flags
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 8'h0C;      // sampled pin levels
  localparam int MODE_LSB = 0;                              // mode field position
  localparam int STAT_RSVD_BIT = 3;                         // reserved mode selected
  localparam int STAT_WIDE_BIT = 4;                         // wide variant built
  localparam logic [2:0] MODE_RST = 3'h0;                   // mode after reset
  localparam logic [3:0] GROUP_SEL_RST = 4'h0;              // all upper groups are flags
  localparam logic [1:0] RESP_OKAY = 2'h0;                  // good response
  localparam logic [1:0] RESP_SLVERR = 2'h2;                // unmapped address

  // pin grouping
  localparam int GRP_LEN = 4;    // pins per group
  localparam int GRP_MID = 2;    // first group of pins 15-8
  localparam int GRP_UPPER = 4;  // first group of pins 31-16
  localparam int ACQ_LSB = 8;    // lowest pin of the acquisition port

  // function of one group of pins
  typedef enum logic [2:0] {
    FN_HIZ = 3'h0,
    FN_EXT = 3'h1,
    FN_HIFLAG = 3'h2,
    FN_LOFLAG = 3'h3,
    FN_ACQ = 3'h4
  } fn_t;

  // decode mode, group index and variant into the group's function
  function automatic fn_t groupFunc(input logic [2:0] mode, input int grp, input logic wide);
    fn_t fn;
    fn = FN_HIZ;
    case (mode)
      MODE_ALL_EXT: fn = FN_EXT;                                                     // RL3 RL10
      MODE_HI_FLAG: fn = (wide && grp >= GRP_UPPER) ? FN_HIFLAG : FN_EXT;            // RL3 RL10
      MODE_MID_FLAG: fn = (grp >= GRP_UPPER) ? FN_HIFLAG : (grp >= GRP_MID) ? FN_LOFLAG : FN_EXT; // RL3 RL10
      MODE_ALL_FLAG: fn = (grp >= GRP_UPPER) ? FN_HIFLAG : FN_LOFLAG;                // RL3 RL10
      MODE_ACQ_EXT: fn = (grp >= GRP_MID) ? FN_ACQ : FN_EXT;                         // RL4 RL10
      MODE_ACQ_FLAG: fn = (grp >= GRP_MID) ? FN_ACQ : FN_LOFLAG;                     // RL5 RL10
      default: fn = FN_HIZ;                                                          // RL6
    endcase
    return fn;
  endfunction

endpackage

// >>> tb/data_pin_function_mux_tb_top.sv
// self-checking bench for the data pin multiplexer, wide and narrow builds
`timescale 1ns/10ps
module data_pin_function_mux_tb_top;
  logic clk = 1'b0, nrst = 1'b0;  // clock and low-active reset
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;  // bus addresses
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic extWrActive = 1'b1;  // external write cycle
  logic [31:0] extWrData = 32'hA5A5_A5A5, pinIn, pinOut, pinOe, extRdData;
  logic [31:0] farData = 32'h0, farOe = 32'h0;  // far side drive
  logic [15:0] loFlagOut = 16'h0FF0, loFlagOe = 16'hFFFF, hiFlagOut = 16'h3C3C, hiFlagOe = 16'hFFFF;
  logic [15:0] pwmOut = 16'hC3C3, loFlagIn, hiFlagIn, nPinIn, nPinOut, nPinOe, nRd;
  logic [23:0] acqData;
  logic [7:0] nAcq;
  int mismatches = 0, total_checks = 0;
  // 8 ns clock
  always #4 clk = ~clk;
  data_pin_function_mux #(.PIN_W(32)) data_pin_function_mux_i (.*);
  // narrow build shares the register bus, answers are left to the wide one
  data_pin_function_mux #(.PIN_W(16)) data_pin_function_mux_narrow_i (.*, .s_axi_awready(), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
    .pinIn(nPinIn), .pinOut(nPinOut), .pinOe(nPinOe), .extWrData(extWrData[15:0]), .extRdData(nRd),
    .loFlagIn(), .hiFlagIn(), .acqData(nAcq));
  pin_far_side #(.W(32)) pin_far_side_i (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .farData(farData),
    .farOe(farOe), .pinIn(pinIn));
  pin_far_side #(.W(16)) pin_far_side_narrow_i (.clk(clk), .pinOut(nPinOut), .pinOe(nPinOe),
    .farData(farData[15:0]), .farOe(farOe[15:0]), .pinIn(nPinIn));
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // bus write: address and data offered together, each released when taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad = 1'b0;
    logic wd = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (s_axi_awready && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !wd) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // bus read
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // let a mode change reach the pins
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // pin function: 0 three-state, 1 external, 2 upper lanes, 3 lower flags, 4 acquisition
  function automatic int fnOf(input int m, input int p, input bit w);
    case (m)
      0: return 1;
      1: return (w && p > 15) ? 2 : 1;
      2: return (p > 15) ? 2 : (p > 7) ? 3 : 1;
      3: return (p > 15) ? 2 : 3;
      4: return (p > 7) ? 4 : 1;
      5: return (p > 7) ? 4 : 3;
      default: return 0;
    endcase
  endfunction
  // one mode, every source enabled: drive mask and driven values on both builds
  task automatic modeCase(input int m);
    logic [31:0] eo [2] = '{2{32'h0}};
    logic [31:0] ev [2] = '{2{32'h0}};
    logic [31:0] d;
    logic [1:0] r;
    int f;
    axiWrite(8'h00, 32'(m), r);
    settle();
    for (int w = 0; w < 2; w++) begin
      for (int p = 0; p < 16 + 16 * w; p++) begin
        f = fnOf(m, p, w[0]);
        eo[w][p] = f inside {1, 2, 3};
        ev[w][p] = (f == 1) ? extWrData[p] : (f == 2) ? hiFlagOut[p % 16] : (f == 3) ? loFlagOut[p % 16] : 1'b0;
      end
    end
    chk("pinOe", eo[1], pinOe);
    chk("pinOut", ev[1], pinOut & eo[1]);
    chk("narrowPinOe", eo[0], {16'h0000, nPinOe});
    chk("narrowPinOut", ev[0], {16'h0000, nPinOut & eo[0][15:0]});
    if (m == 3) chk("flagIn", {hiFlagOut, loFlagOut}, {hiFlagIn, loFlagIn});
    axiRead(8'h08, d, r);
    chk("status", {27'h0, 2'b10, m[2:0]}, d);
  endtask
  // pwm on upper groups 0 and 2 (pins 19-16 and 27-24), upper flag enables off: pwm groups drive, across two modes
  task automatic groupCase;
    logic [31:0] d;
    logic [1:0] r;
    axiWrite(8'h00, 32'h1, r);
    axiWrite(8'h04, 32'h5, r);
    @(posedge clk);
    hiFlagOe <= 16'h0000;
    settle();
    chk("pinOe", 32'h0F0F_FFFF, pinOe);
    chk("pinOut", {pwmOut & 16'h0F0F, extWrData[15:0]}, pinOut & 32'h0F0F_FFFF);
    axiWrite(8'h00, 32'h3, r);
    settle();
    chk("pinOe", 32'h0F0F_FFFF, pinOe);
    chk("pinOut", {pwmOut & 16'h0F0F, loFlagOut}, pinOut & 32'h0F0F_FFFF);
    axiRead(8'h04, d, r);
    chk("groupSel", 32'h5, d);
    axiWrite(8'h04, 32'h0, r);
    hiFlagOe <= 16'hFFFF;
  endtask
  // no write cycle: external pins release and read; acquisition pins stay inputs
  task automatic inputCase;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    extWrActive <= 1'b0;
    farOe <= 32'hFFFF_FFFF;
    farData <= 32'h1357_9BDF;
    axiWrite(8'h00, 32'h0, r);
    settle();
    chk("pinOe", 32'h0, pinOe);
    chk("extRdData", farData, extRdData);
    chk("narrowRd", {16'h0, farData[15:0]}, {16'h0, nRd});
    axiRead(8'h0C, d, r);
    chk("pinLevel", farData, d);
    axiWrite(8'h00, 32'h4, r);
    extWrActive <= 1'b1;
    settle();
    chk("pinOe", 32'h0000_00FF, pinOe);
    chk("acqData", {8'h0, farData[31:8]}, {8'h0, acqData});
    chk("narrowAcq", {24'h0, farData[15:8]}, {24'h0, nAcq});
    @(posedge clk);
    farOe <= 32'h0;
  endtask
  // unmapped offset: error on both directions, mode kept
  task automatic unmappedCase;
    logic [31:0] d;
    logic [1:0] r;
    axiWrite(8'h10, 32'h7, r);
    chk("bresp", 32'(pin_mux_pkg::RESP_SLVERR), 32'(r));
    axiRead(8'h10, d, r);
    chk("rresp", 32'(pin_mux_pkg::RESP_SLVERR), 32'(r));
    chk("rdata", 32'h0, d);
    s_axi_wstrb <= 4'h0;
    axiWrite(8'h00, 32'h0, r);
    s_axi_wstrb <= 4'hF;
    axiRead(8'h00, d, r);
    chk("mode", 32'h4, d);
  endtask
  // verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence; the reserved code is never selected
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      if (m != 6) modeCase(m);
    end
    groupCase();
    inputCase();
    unmappedCase();
    test_done();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule  // data_pin_function_mux_tb_top

// >>> tb/pin_far_side.sv
// far side of the shared data pins: memory, acquisition source and flag loads
`timescale 1ns/10ps
module pin_far_side #(
  parameter int W = 32  // pin count
) (
  input wire logic clk,
  input wire logic [W-1:0] pinOut,
  input wire logic [W-1:0] pinOe,
  input wire logic [W-1:0] farData,
  input wire logic [W-1:0] farOe,
  output logic [W-1:0] pinIn
);
  // last resolved level, so an undriven pin never holds still
  logic [W-1:0] lastLevel_reg = '0;
  // device drive first; the far side only drives pins the device released
  assign pinIn = (pinOe & pinOut) | (~pinOe & farOe & farData) | (~pinOe & ~farOe & ~lastLevel_reg);
  // floating pins flip every cycle
  always @(posedge clk) begin
    lastLevel_reg <= pinIn;
  end
endmodule  // pin_far_side

// >>> verilog/data_pin_function_mux.sv
// data pin function multiplexer with its AXI4-Lite register slave
// Function
// RL1: wide variant routes 32 pins by mode field
// RL2: acquisition pins input only; others bidirectional
// RL3: wide modes 000 to 011 pin assignment
// RL4: mode 100: acquisition upper, external data low
// RL5: mode 101: acquisition upper, flags on 7-0
// RL6: 110 reserved; 111 three-states every pin
// RL7: flag or pwm chosen per four lanes
// RL8: group select independent of pin mode
// RL9: narrow variant muxes 16 pins same field
// RL10: narrow variant mode table for 16 pins
// RL11: external data drives on writes; mode next edge
`timescale 1ns/10ps
module data_pin_function_mux #(
  parameter int PIN_W = 32  // 32 for the wide variant, 16 for the narrow one
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PIN_W-1:0] pinIn,
  output logic [PIN_W-1:0] pinOut,
  output logic [PIN_W-1:0] pinOe,
  input wire logic [PIN_W-1:0] extWrData,
  input wire logic extWrActive,
  output logic [PIN_W-1:0] extRdData,
  input wire logic [15:0] loFlagOut,
  input wire logic [15:0] loFlagOe,
  output logic [15:0] loFlagIn,
  input wire logic [15:0] hiFlagOut,
  input wire logic [15:0] hiFlagOe,
  input wire logic [15:0] pwmOut,
  output logic [15:0] hiFlagIn,
  output logic [PIN_W-9:0] acqData
);

  localparam int GROUPS = PIN_W / pin_mux_pkg::GRP_LEN;  // four-pin groups
  localparam logic WIDE = (PIN_W == 32);                   // wide variant flag

  // configuration state
  logic [2:0] mode_reg;        // pin mode field of the system control register
  logic [2:0] mode_next;
  logic [3:0] groupSel_reg;    // one bit per upper group: 1 pwm, 0 flag
  logic [3:0] groupSel_next;
  logic [PIN_W-1:0] pinLevel_reg;  // sampled pins for software

  // write channel state
  logic awHave_reg;            // write address held
  logic awHave_next;
  logic wHave_reg;             // write data held
  logic wHave_next;
  logic [pin_mux_pkg::ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic awReady_next;
  logic wReady_next;
  logic bValid_next;

  // read channel state
  logic arReady_next;
  logic rValid_next;

  // handshakes and decode
  logic awTake;     // write address accepted this edge
  logic wTake;      // write data accepted this edge
  logic arTake;     // read address accepted this edge
  logic doWrite;    // both halves present, response slot free
  logic wrCtrl;     // write hits the system control register
  logic wrGroup;    // write hits the group select register
  logic wrHit;      // write hits a writable register
  logic rdHit;      // read hits a mapped register
  logic [31:0] rdWord;      // selected read data
  logic [31:0] statusWord;  // status register image
  logic reservedSel;        // software chose the reserved code

  assign awTake = s_axi_awvalid && s_axi_awready;
  assign wTake = s_axi_wvalid && s_axi_wready;
  assign arTake = s_axi_arvalid && s_axi_arready;
  assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
  assign wrCtrl = (awAddr_reg == pin_mux_pkg::OFS_SYS_CTRL);
  assign wrGroup = (awAddr_reg == pin_mux_pkg::OFS_GROUP_SEL);
  assign wrHit = wrCtrl || wrGroup;

  // address and data are held independently, released by the write itself
  assign awHave_next = (awHave_reg || awTake) && !doWrite;
  assign wHave_next = (wHave_reg || wTake) && !doWrite;
  assign awReady_next = !awHave_next;
  assign wReady_next = !wHave_next;
  assign bValid_next = doWrite || (s_axi_bvalid && !s_axi_bready);

  // a new mode is stored on the write edge and reaches the pins one edge later
  assign mode_next = (doWrite && wrCtrl && wStrb_reg[0]) ? wData_reg[pin_mux_pkg::MODE_LSB +: 3] : mode_reg; // RL11
  assign groupSel_next = (doWrite && wrGroup && wStrb_reg[0]) ? wData_reg[3:0] : groupSel_reg;          // RL8

  // read decode; unmapped offsets answer zero with an error
  assign reservedSel = (mode_reg == pin_mux_pkg::MODE_RESERVED);
  assign statusWord = {27'h0, WIDE, reservedSel, mode_reg};
  assign rdHit = (s_axi_araddr == pin_mux_pkg::OFS_SYS_CTRL) || (s_axi_araddr == pin_mux_pkg::OFS_GROUP_SEL) ||
                 (s_axi_araddr == pin_mux_pkg::OFS_STATUS) || (s_axi_araddr == pin_mux_pkg::OFS_PIN_LEVEL);
  assign rdWord = (s_axi_araddr == pin_mux_pkg::OFS_SYS_CTRL) ? {29'h0, mode_reg} :
                  (s_axi_araddr == pin_mux_pkg::OFS_GROUP_SEL) ? {28'h0, groupSel_reg} :
                  (s_axi_araddr == pin_mux_pkg::OFS_STATUS) ? statusWord :
                  (s_axi_araddr == pin_mux_pkg::OFS_PIN_LEVEL) ? 32'(pinLevel_reg) : 32'h0;
  assign rValid_next = arTake || (s_axi_rvalid && !s_axi_rready);
  assign arReady_next = !rValid_next;

  // write channel registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      awHave_reg <= awHave_next;
      wHave_reg <= wHave_next;
      s_axi_awready <= awReady_next;
      s_axi_wready <= wReady_next;
      s_axi_bvalid <= bValid_next;
    end
  end

  // write payload capture and response code
  always_ff @(posedge clk) begin
    if (!nrst) begin
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      s_axi_bresp <= pin_mux_pkg::RESP_OKAY;
    end else begin
      if (awTake) awAddr_reg <= s_axi_awaddr;
      if (wTake) wData_reg <= s_axi_wdata;
      if (wTake) wStrb_reg <= s_axi_wstrb;
      if (doWrite) s_axi_bresp <= wrHit ? pin_mux_pkg::RESP_OKAY : pin_mux_pkg::RESP_SLVERR;
    end
  end

  // read channel registers; data held while the master stalls
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= pin_mux_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= arReady_next;
      s_axi_rvalid <= rValid_next;
      if (arTake) s_axi_rdata <= rdWord;
      if (arTake) s_axi_rresp <= rdHit ? pin_mux_pkg::RESP_OKAY : pin_mux_pkg::RESP_SLVERR;
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_reg <= pin_mux_pkg::MODE_RST;
      groupSel_reg <= pin_mux_pkg::GROUP_SEL_RST;
    end else begin
      mode_reg <= mode_next;
      groupSel_reg <= groupSel_next;
    end
  end

  // per-pin function masks, used to steer captured inputs
  logic [PIN_W-1:0] extMask;   // pins carrying external data
  logic [PIN_W-1:0] acqMask;   // pins carrying the acquisition port
  logic [15:0] loFlagIn_next;  // lower flag lanes seen on the pins
  logic [15:0] hiFlagIn_next;  // upper flag lanes seen on the pins
  logic [PIN_W-1:0] extRdData_next;
  logic [PIN_W-9:0] acqData_next;

  // one decoder and one driver cell per four-pin group
  for (genvar g = 0; g < GROUPS; g++) begin : gen_group
    pin_mux_pkg::fn_t fn;   // this group's function
    logic [3:0] loO;        // lower flag level for this group
    logic [3:0] loE;        // lower flag enable
    logic [3:0] hiO;        // upper flag level
    logic [3:0] hiE;        // upper flag enable
    logic [3:0] pwm;        // pwm level
    logic pwmSel;           // group drives pwm instead of flags

    assign fn = pin_mux_pkg::groupFunc(mode_reg, g, WIDE);  // RL1 RL9
    assign extMask[4*g +: 4] = {4{fn == pin_mux_pkg::FN_EXT}};
    assign acqMask[4*g +: 4] = {4{fn == pin_mux_pkg::FN_ACQ}};

    if (g < pin_mux_pkg::GRP_UPPER) begin : gen_low
      // lower pins: flag lane index equals pin index
      assign loO = loFlagOut[4*g +: 4];
      assign loE = loFlagOe[4*g +: 4];
      assign hiO = 4'h0;
      assign hiE = 4'h0;
      assign pwm = 4'h0;
      assign pwmSel = 1'b0;
      assign loFlagIn_next[4*g +: 4] = pinIn[4*g +: 4] & {4{fn == pin_mux_pkg::FN_LOFLAG}};
    end else begin : gen_high
      // upper pins 31-16 carry flag/pwm lanes 15-0
      assign loO = 4'h0;
      assign loE = 4'h0;
      assign hiO = hiFlagOut[4*(g-4) +: 4];
      assign hiE = hiFlagOe[4*(g-4) +: 4];
      assign pwm = pwmOut[4*(g-4) +: 4];
      assign pwmSel = groupSel_reg[g-4];  // RL7 RL8
      assign hiFlagIn_next[4*(g-4) +: 4] = pinIn[4*g +: 4] & {4{fn == pin_mux_pkg::FN_HIFLAG}};
    end

    pin_group_cell u_cell (
      .clk(clk),
      .nrst(nrst),
      .fnSel(fn),
      .pwmSel(pwmSel),
      .extData(extWrData[4*g +: 4]),
      .extWrActive(extWrActive),
      .hiOut(hiO),
      .hiOe(hiE),
      .pwmIn(pwm),
      .loOut(loO),
      .loOe(loE),
      .pinOut(pinOut[4*g +: 4]),
      .pinOe(pinOe[4*g +: 4])
    );
  end

  // the narrow variant has no upper flag lanes
  if (PIN_W < 32) begin : gen_no_high
    assign hiFlagIn_next = 16'h0;
  end

  // inputs: only pins owned by a function reach that function, others read zero
  assign extRdData_next = pinIn & extMask;
  assign acqData_next = pinIn[PIN_W-1:pin_mux_pkg::ACQ_LSB] & acqMask[PIN_W-1:pin_mux_pkg::ACQ_LSB]; // RL2

  // input capture registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      extRdData <= '0;
      loFlagIn <= 16'h0;
      hiFlagIn <= 16'h0;
      acqData <= '0;
      pinLevel_reg <= '0;
    end else begin
      extRdData <= extRdData_next;
      loFlagIn <= loFlagIn_next;
      hiFlagIn <= hiFlagIn_next;
      acqData <= acqData_next;
      pinLevel_reg <= pinIn;
    end
  end

  // three-state code releases every pin one edge later
  AST_HIZ_ALL: assert property (@(posedge clk) disable iff (!nrst) // RL6
    (mode_reg == pin_mux_pkg::MODE_ALL_HIZ || mode_reg == pin_mux_pkg::MODE_RESERVED) |=> (pinOe == '0))
    else $error("pins driven in three-state mode");

  // acquisition pins never drive
  AST_ACQ_INPUT_ONLY: assert property (@(posedge clk) disable iff (!nrst) // RL2 RL4 RL5 RL9
    (mode_reg == pin_mux_pkg::MODE_ACQ_EXT || mode_reg == pin_mux_pkg::MODE_ACQ_FLAG)
    |=> (pinOe[PIN_W-1:pin_mux_pkg::ACQ_LSB] == '0))
    else $error("acquisition pin driven");

  // external data pins are released outside write cycles
  AST_EXT_IDLE_RELEASE: assert property (@(posedge clk) disable iff (!nrst) // RL11
    (mode_reg == pin_mux_pkg::MODE_ALL_EXT && !extWrActive) |=> (pinOe == '0))
    else $error("external data pins driven without a write");

  // full external data mode drives every pin with write data
  AST_EXT_WRITE_DRIVE: assert property (@(posedge clk) disable iff (!nrst) // RL3 RL10
    (mode_reg == pin_mux_pkg::MODE_ALL_EXT && extWrActive) |=> (pinOe == '1 && pinOut == $past(extWrData)))
    else $error("external write not driven on all pins");

  // mode 100 keeps external data on pins 7-0
  AST_ACQ_EXT_LOW: assert property (@(posedge clk) disable iff (!nrst) // RL4 RL10
    (mode_reg == pin_mux_pkg::MODE_ACQ_EXT && extWrActive)
    |=> (pinOe[7:0] == 8'hFF && pinOut[7:0] == $past(extWrData[7:0])))
    else $error("external data missing on low pins in mode 100");

  // mode 101 puts lower flag lanes 7-0 on pins 7-0
  AST_ACQ_FLAG_LOW: assert property (@(posedge clk) disable iff (!nrst) // RL5 RL10
    (mode_reg == pin_mux_pkg::MODE_ACQ_FLAG)
    |=> (pinOe[7:0] == $past(loFlagOe[7:0]) && pinOut[7:0] == $past(loFlagOut[7:0])))
    else $error("flag lanes missing on low pins in mode 101");

  // a written mode is in force two edges after the write
  AST_MODE_UPDATE: assert property (@(posedge clk) disable iff (!nrst) // RL11
    (doWrite && wrCtrl && wStrb_reg[0])
    |=> (mode_reg == $past(wData_reg[2:0])) ##1 (mode_reg != pin_mux_pkg::MODE_ALL_HIZ || pinOe == '0))
    else $error("mode write not taken");

  // every write gets its response one edge later, held until taken
  AST_WRITE_RESP: assert property (@(posedge clk) disable iff (!nrst)
    doWrite |=> s_axi_bvalid ##0 (s_axi_bresp == ($past(wrHit) ? pin_mux_pkg::RESP_OKAY : pin_mux_pkg::RESP_SLVERR)))
    else $error("write response wrong or late");

  // read data stay put while the master stalls
  AST_READ_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata) && !s_axi_arready))
    else $error("read data changed under stall");

  // mode 010 puts lower flag lanes 15-8 on pins 15-8
  AST_MID_FLAG: assert property (@(posedge clk) disable iff (!nrst) // RL3 RL10
    (mode_reg == pin_mux_pkg::MODE_MID_FLAG)
    |=> (pinOe[15:8] == $past(loFlagOe[15:8]) && pinOut[15:8] == $past(loFlagOut[15:8])))
    else $error("flag lanes missing on pins 15-8 in mode 010");

  // mode 011 puts all lower flag lanes on pins 15-0
  AST_ALL_FLAG: assert property (@(posedge clk) disable iff (!nrst) // RL3 RL10
    (mode_reg == pin_mux_pkg::MODE_ALL_FLAG)
    |=> (pinOe[15:0] == $past(loFlagOe) && pinOut[15:0] == $past(loFlagOut)))
    else $error("flag lanes missing on pins 15-0 in mode 011");

  // lower flag inputs follow the pins in mode 011
  AST_FLAG_READ: assert property (@(posedge clk) disable iff (!nrst) // RL2 RL3
    (mode_reg == pin_mux_pkg::MODE_ALL_FLAG) |=> (loFlagIn == $past(pinIn[15:0])))
    else $error("flag inputs not captured in mode 011");

  // external read data follow every pin in mode 000
  AST_EXT_READ: assert property (@(posedge clk) disable iff (!nrst) // RL1 RL9
    (mode_reg == pin_mux_pkg::MODE_ALL_EXT) |=> (extRdData == $past(pinIn)))
    else $error("external read data not captured");

  // acquisition inputs follow the upper pins in modes 100 and 101
  AST_ACQ_CAPTURE: assert property (@(posedge clk) disable iff (!nrst) // RL4 RL5
    (mode_reg == pin_mux_pkg::MODE_ACQ_EXT || mode_reg == pin_mux_pkg::MODE_ACQ_FLAG)
    |=> (acqData == $past(pinIn[PIN_W-1:pin_mux_pkg::ACQ_LSB])))
    else $error("acquisition data not captured");

  if (PIN_W == 32) begin : gen_wide_checks
    // mode 001 puts upper lanes on pins 31-16, pwm by group select
    AST_UPPER_PWM: assert property (@(posedge clk) disable iff (!nrst) // RL3 RL7 RL8
      (mode_reg == pin_mux_pkg::MODE_HI_FLAG && groupSel_reg[0])
      |=> (pinOe[19:16] == 4'hF && pinOut[19:16] == $past(pwmOut[3:0])))
      else $error("upper pwm group not driven");
  end else begin : gen_narrow_checks
    // narrow mode 001 is full external data
    AST_NARROW_MODE1: assert property (@(posedge clk) disable iff (!nrst) // RL10
      (mode_reg == pin_mux_pkg::MODE_HI_FLAG && extWrActive) |=> (pinOe == '1))
      else $error("narrow mode 001 not external data");
  end

endmodule // data_pin_function_mux

// >>> verilog/pin_group_cell.sv
// registered output driver for one group of four shared data pins
`timescale 1ns/10ps
module pin_group_cell (
  input wire logic clk,
  input wire logic nrst,
  input wire pin_mux_pkg::fn_t fnSel,
  input wire logic pwmSel,
  input wire logic [3:0] extData,
  input wire logic extWrActive,
  input wire logic [3:0] hiOut,
  input wire logic [3:0] hiOe,
  input wire logic [3:0] pwmIn,
  input wire logic [3:0] loOut,
  input wire logic [3:0] loOe,
  output logic [3:0] pinOut,
  output logic [3:0] pinOe
);

  // selected level for each function; pwm replaces the whole group, never one pin
  logic [3:0] hiLevel;   // flag or pwm level on an upper group
  logic [3:0] hiEnable;  // flag enable, or always on for pwm
  logic [3:0] pinOut_next;  // next pin level
  logic [3:0] pinOe_next;   // next pin enable

  assign hiLevel = pwmSel ? pwmIn : hiOut;  // RL7 RL8
  assign hiEnable = pwmSel ? 4'hF : hiOe;   // RL7 RL8

  // external data drives only during a write cycle; acquisition pins never drive
  assign pinOut_next = (fnSel == pin_mux_pkg::FN_EXT) ? extData :
                       (fnSel == pin_mux_pkg::FN_HIFLAG) ? hiLevel :
                       (fnSel == pin_mux_pkg::FN_LOFLAG) ? loOut : 4'h0;
  assign pinOe_next = (fnSel == pin_mux_pkg::FN_EXT) ? {4{extWrActive}} :             // RL11 RL2
                      (fnSel == pin_mux_pkg::FN_HIFLAG) ? hiEnable :                  // RL2
                      (fnSel == pin_mux_pkg::FN_LOFLAG) ? loOe : 4'h0;                // RL2 RL6

  // pin registers, released to high impedance at reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pinOut <= 4'h0;
      pinOe <= 4'h0;
    end else begin
      pinOut <= pinOut_next;
      pinOe <= pinOe_next;
    end
  end

  // a pwm group drives all four pins at once
  AST_PWM_GROUP: assert property (@(posedge clk) disable iff (!nrst) // RL7
    (fnSel == pin_mux_pkg::FN_HIFLAG && pwmSel) |=> (pinOe == 4'hF && pinOut == $past(pwmIn)))
    else $error("pwm group did not drive all four pins");

endmodule // pin_group_cell
